// ---- rtl/mdo_pkg.sv ----
/*
 * mdo_pkg: constants and carrier types for the motor drive output stage.
 * assumes a single 10 MHz system clock; the pwm periods and duty counts are derived from it.
 */
package mdo_pkg;
  localparam int CLK_HZ     = 10_000_000;
  localparam int INV_PWM_HZ = 25_000;
  localparam int SM_PWM_HZ  = 50_000;
  // duty endpoints in tenths of a percent
  localparam int INV_MIN_PM = 2;
  localparam int INV_MAX_PM = 998;
  localparam int SM_MAX_PM  = 996;

  localparam int CNT_W  = 9;
  localparam int CMD_W  = 16;
  localparam int STEP_W = 16;
  localparam int AXES   = 8;
  localparam int OUT_N  = 8;
  localparam int IDX_W  = 3;
  localparam int SCALE_SH = CMD_W - 1;

  localparam int INV_PERIOD = CLK_HZ / INV_PWM_HZ;
  localparam int SM_PERIOD  = CLK_HZ / SM_PWM_HZ;
  localparam int INV_MID    = INV_PERIOD / 2;
  // least duty rounds up, greatest rounds down
  localparam int INV_MIN_HI = (INV_PERIOD * INV_MIN_PM + 999) / 1000;
  localparam int INV_MAX_HI = (INV_PERIOD * INV_MAX_PM) / 1000;
  localparam int SM_MAX_HI  = (SM_PERIOD * SM_MAX_PM) / 1000;
  localparam int INV_SPAN   = INV_MAX_HI - INV_MID;

  localparam logic [CNT_W-1:0] INV_LAST = CNT_W'(INV_PERIOD - 1);
  localparam logic [CNT_W-1:0] SM_LAST  = CNT_W'(SM_PERIOD - 1);
  localparam logic [CMD_W-1:0] CMD_RST  = 16'h0000;
  localparam logic [OUT_N-1:0] OUT_RST  = 8'h00;

  typedef struct packed {
    logic              run;
    logic              dir;
    logic              pol_high;
    logic [STEP_W-1:0] half_period;
  } mdo_step_cfg_t;

  typedef struct packed {
    logic             set_bit;
    logic             clr_bit;
    logic             port_wr;
    logic [IDX_W-1:0] idx;
    logic [OUT_N-1:0] data;
  } mdo_out_cmd_t;
endpackage

// ---- rtl/mdo_drive.sv ----
/*
 * mdo_drive: one axis of motor drive output (command word, amp enable,
 * inverter / sign-magnitude pwm or step and direction), the shared
 * position-error output and a bank of general purpose outputs.
 * assumes all inputs are synchronous to clock; the servo filter supplies
 * a new command with a one-cycle sample strobe and the pin wire is
 * resolved outside from pwm_step_out and pwm_step_oe_n.
 */
`timescale 1ns/10ps
module mdo_drive (
  // clock and reset
  input  wire logic                              clock,
  input  wire logic                              rst_n,
  // command from the servo filter
  input  wire logic signed [mdo_pkg::CMD_W-1:0]  motor_cmd,
  input  wire logic                              sample_stb,
  input  wire logic                              motor_off,
  input  wire logic [mdo_pkg::CMD_W-1:0]         offset_level_setting,
  // mode and safety
  input  wire logic                              sign_magnitude_select,
  input  wire logic                              stepper_mode,
  input  wire logic                              pwm_enable,
  input  wire logic                              abort_n,
  input  wire logic                              off_on_error_setting,
  input  wire logic                              amp_on_cmd,
  input  wire mdo_pkg::mdo_step_cfg_t            step_cfg,
  // position error of every axis
  input  wire logic [mdo_pkg::AXES-1:0][mdo_pkg::CMD_W-1:0] pos_err_mag,
  input  wire logic [mdo_pkg::CMD_W-1:0]         error_limit_setting,
  // general outputs command
  input  wire mdo_pkg::mdo_out_cmd_t             out_cmd,
  // outputs
  output logic [mdo_pkg::CMD_W-1:0]              motor_cmd_out,
  output logic                                   amp_enable,
  output logic                                   pwm_step_out,
  output logic                                   pwm_step_oe_n,
  output logic                                   sign_dir_out,
  output logic                                   error_out_n,
  output logic [mdo_pkg::OUT_N-1:0]              gp_out
);
  import mdo_pkg::*;

  logic               rst_meta_reg, rst_sync_reg;
  logic [CMD_W-1:0]   cmd_reg, cmd_next;
  logic               trip_reg;
  logic [CNT_W-1:0]   pwm_cnt_reg, duty_reg;
  logic               sign_reg;
  logic               sign_out_reg;
  logic [CNT_W:0]     gap_cnt_reg;
  logic [STEP_W-1:0]  step_cnt_reg;
  logic               step_phase_reg, step_dir_reg;
  logic [OUT_N-1:0]   gp_reg, gp_next;
  logic               pwm_out_reg, oe_n_reg, amp_reg, err_n_reg;

  // reset release through two flops; the first is read only by the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // command word
  assign cmd_next = motor_off  ? offset_level_setting :
                    sample_stb ? motor_cmd : cmd_reg;

  // mode decode; a stepper without the select fitted is not honoured
  wire stepper  = stepper_mode & sign_magnitude_select;
  wire sm_servo = sign_magnitude_select & ~stepper;
  wire [CNT_W-1:0] last = sm_servo ? SM_LAST : INV_LAST;
  wire period_end = (pwm_cnt_reg == last) || (pwm_cnt_reg > last);

  // inverter duty: mid plus scaled signed command, clamped
  wire signed [24:0] inv_prod = $signed(cmd_reg) * 25'(INV_SPAN);
  wire signed [24:0] inv_raw  = 25'(INV_MID) + (inv_prod >>> SCALE_SH);
  wire [CNT_W-1:0] inv_hi =
    (inv_raw < 25'(INV_MIN_HI)) ? CNT_W'(INV_MIN_HI) :
    (inv_raw > 25'(INV_MAX_HI)) ? CNT_W'(INV_MAX_HI) :
                                  inv_raw[CNT_W-1:0];
  // sign-magnitude duty from magnitude
  wire              cmd_neg = cmd_reg[CMD_W-1];
  wire [CMD_W:0]    mag     = cmd_neg ? 17'(-$signed({1'b1, cmd_reg}))
                                      : {1'b0, cmd_reg};
  wire [24:0]       sm_prod = 25'(mag) * 25'(SM_MAX_HI);
  wire [24:0]       sm_sh   = sm_prod >> SCALE_SH;
  wire [CNT_W-1:0]  sm_hi   = (sm_sh > 25'(SM_MAX_HI)) ? CNT_W'(SM_MAX_HI)
                                                       : sm_sh[CNT_W-1:0];
  wire pwm_level = pwm_cnt_reg < duty_reg;

  // step generator: equal high and low halves
  wire [STEP_W-1:0] half_last = step_cfg.half_period - 16'h0001;
  wire step_go  = stepper & step_cfg.run & (step_cfg.half_period != 16'h0000);
  wire step_tgl = step_go & (step_cnt_reg >= half_last);
  wire step_lvl = step_phase_reg ^ ~step_cfg.pol_high;

  // error compare across axes
  logic [AXES-1:0] over;
  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_err
      assign over[g] = pos_err_mag[g] > error_limit_setting;
    end
  endgenerate
  wire any_over = |over;

  // amp trip: latched on abort or error, released by amp_on_cmd
  wire trip_set  = ~abort_n | (off_on_error_setting & any_over);
  wire trip_next = trip_set | (trip_reg & ~amp_on_cmd);

  // general outputs; port write first, then set, then clear
  always_comb begin
    gp_next = gp_reg;
    if (out_cmd.port_wr) begin
      gp_next = out_cmd.data;
    end else if (out_cmd.set_bit) begin
      gp_next[out_cmd.idx] = 1'b1;
    end else if (out_cmd.clr_bit) begin
      gp_next[out_cmd.idx] = 1'b0;
    end
  end

  wire drive = sign_magnitude_select | pwm_enable;
  wire out_next  = stepper ? step_lvl : (drive & pwm_level);
  // direction only moves while the step line is idle or at pulse start
  wire dir_load  = ~step_phase_reg;
  wire sign_next = stepper ? step_dir_reg : sign_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg        <= CMD_RST;
      trip_reg       <= 1'b1;
      pwm_cnt_reg    <= '0;
      duty_reg       <= '0;
      sign_reg       <= 1'b0;
      step_cnt_reg   <= '0;
      step_phase_reg <= 1'b0;
      step_dir_reg   <= 1'b0;
      gp_reg         <= OUT_RST;
    end else if (!rst_sync_reg) begin
      trip_reg       <= 1'b1;
    end else begin
      cmd_reg     <= cmd_next;
      trip_reg    <= trip_next;
      gp_reg      <= gp_next;
      pwm_cnt_reg <= period_end ? '0 : pwm_cnt_reg + 9'h001;
      if (period_end) begin
        duty_reg <= sm_servo ? sm_hi : inv_hi;
        sign_reg <= cmd_neg;
      end
      step_cnt_reg <= (step_tgl | ~step_go) ? '0 : step_cnt_reg + 16'h0001;
      if (step_tgl) begin
        step_phase_reg <= ~step_phase_reg;
      end else if (!step_go) begin
        step_phase_reg <= 1'b0;
      end
      if (dir_load) begin
        step_dir_reg <= step_cfg.dir;
      end
    end
  end

  // pin stage; tristate under reset, driven low after release if fitted
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pwm_out_reg  <= 1'b0;
      oe_n_reg     <= 1'b1;
      amp_reg      <= 1'b0;
      err_n_reg    <= 1'b1;
      sign_out_reg <= 1'b0;
    end else if (!rst_sync_reg) begin
      pwm_out_reg  <= 1'b0;
      oe_n_reg     <= ~sign_magnitude_select;
      amp_reg      <= 1'b0;
      err_n_reg    <= 1'b1;
      sign_out_reg <= 1'b0;
    end else begin
      pwm_out_reg  <= out_next;
      oe_n_reg     <= ~(drive | stepper);
      amp_reg      <= ~trip_next;
      err_n_reg    <= ~any_over;
      // registered beside the pin so polarity and pulse move together
      sign_out_reg <= sign_next;
    end
  end

  // cycles between inverter wraps, kept apart from the pwm counter;
  // all ones marks an unknown start, e.g. after a mode change
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gap_cnt_reg <= '1;
    end else if (!rst_sync_reg || sign_magnitude_select) begin
      gap_cnt_reg <= '1;
    end else if (pwm_cnt_reg == INV_LAST) begin
      gap_cnt_reg <= '0;
    end else if (gap_cnt_reg != '1) begin
      gap_cnt_reg <= gap_cnt_reg + 10'h001;
    end
  end

  assign motor_cmd_out = cmd_reg;
  assign amp_enable    = amp_reg;
  assign pwm_step_out  = pwm_out_reg;
  assign pwm_step_oe_n = oe_n_reg;
  assign sign_dir_out  = sign_out_reg;
  assign error_out_n   = err_n_reg;
  assign gp_out        = gp_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_reg);

  sequence s_abort;
    !abort_n;
  endsequence
  // second cycle may rise only if a release was asked for after the abort
  sequence s_amp_low;
    !amp_enable ##1 (!amp_enable || $past(amp_on_cmd));
  endsequence

  property p_cmd_load;
    !motor_off && sample_stb |=> motor_cmd_out == $past(motor_cmd);
  endproperty
  a_cmd_load: assert property (p_cmd_load) else $error("cmd not loaded");
  property p_off_hold;
    motor_off |=> motor_cmd_out == $past(offset_level_setting);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("offset not held");
  property p_abort;
    s_abort |=> s_amp_low;
  endproperty
  a_abort: assert property (p_abort) else $error("amp on after abort");
  property p_inv_range;
    inv_hi >= 9'(INV_MIN_HI) && inv_hi <= 9'(INV_MAX_HI);
  endproperty
  a_inv_range: assert property (p_inv_range) else $error("inv duty range");
  property p_inv_period;
    !sign_magnitude_select && pwm_cnt_reg == INV_LAST && gap_cnt_reg != '1
      |-> gap_cnt_reg == {1'b0, INV_LAST};
  endproperty
  a_inv_period: assert property (p_inv_period) else $error("inv period");
  property p_sm_sign;
    sm_servo && period_end |=> ##1 sign_dir_out == $past(cmd_neg, 2);
  endproperty
  a_sm_sign: assert property (p_sm_sign) else $error("sign mismatch");
  property p_sm_duty;
    sm_servo |-> sm_hi <= 9'(SM_MAX_HI) && (cmd_reg != '0 || sm_hi == '0);
  endproperty
  a_sm_duty: assert property (p_sm_duty) else $error("sm duty range");
  property p_step_half;
    step_go && $changed(step_phase_reg) |-> $past(step_tgl);
  endproperty
  a_step_half: assert property (p_step_half) else $error("step half");
  property p_err;
    any_over |=> !error_out_n;
  endproperty
  a_err: assert property (p_err) else $error("error out not low");
  property p_set_bit;
    out_cmd.set_bit && !out_cmd.port_wr |=> gp_out[$past(out_cmd.idx)];
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("set bit lost");
  property p_port_wr;
    out_cmd.port_wr |=> gp_out == $past(out_cmd.data);
  endproperty
  a_port_wr: assert property (p_port_wr) else $error("port write lost");
endmodule

// ---- sim/mdo_amp_model.sv ----
/*
 * mdo_amp_model: far-side power bridge or step driver for one axis.
 * resolves the pwm/step pin from level and enable, counts high cycles and
 * rising edges since the last clear; assumes clr is a one-cycle pulse.
 */
`timescale 1ns/10ps
module mdo_amp_model (
  // clock and window control
  input  wire logic clock,
  input  wire logic clr,
  // pin as driven by the stage
  input  wire logic pwm_step_out,
  input  wire logic pwm_step_oe_n,
  // observations
  output wire       pin,
  output int        hi_cnt,
  output int        edge_cnt
);
  logic prev;
  // no pull on the pin: an undriven pin floats
  assign pin = pwm_step_oe_n ? 1'bz : pwm_step_out;
  always_ff @(posedge clock) begin
    prev <= pin;
    if (clr) begin
      hi_cnt   <= 0;
      edge_cnt <= 0;
    end else begin
      hi_cnt   <= hi_cnt + int'(pin === 1'b1);
      edge_cnt <= edge_cnt + int'(pin === 1'b1 && prev !== 1'b1);
    end
  end
endmodule

// ---- sim/test_mdo_drive.sv ----
/*
 * test_mdo_drive: self-checking bench for the motor drive output stage.
 * assumes mdo_pkg and mdo_drive are compiled first; pin behaviour is
 * observed through the amplifier model.
 */
`timescale 1ns/10ps
module test_mdo_drive;
  import mdo_pkg::*;
  logic                            clock = 0, rst_n = 0, clr = 0;
  logic signed [CMD_W-1:0]         motor_cmd = '0;
  logic                            sample_stb = 0, motor_off = 0;
  logic [CMD_W-1:0]                offset_level_setting = 16'h1234;
  logic                            sign_magnitude_select = 0;
  logic                            stepper_mode = 0, pwm_enable = 1;
  logic                            abort_n = 1, off_on_error_setting = 0;
  logic                            amp_on_cmd = 0;
  mdo_step_cfg_t                   step_cfg = '0;
  logic [AXES-1:0][CMD_W-1:0]      pos_err_mag = '0;
  logic [CMD_W-1:0]                error_limit_setting = 16'h0100;
  mdo_out_cmd_t                    out_cmd = '0;
  logic [CMD_W-1:0]                motor_cmd_out;
  logic [OUT_N-1:0]                gp_out;
  logic                            amp_enable, pwm_step_out, pwm_step_oe_n;
  logic                            sign_dir_out, error_out_n;
  wire                             pin;
  int                              hi_cnt, edge_cnt, bad_count, check_count;
  int                              cyc;
  int                              cmds[4] = '{-32768, 0, 32767, 16384};

  mdo_drive DUT (.clock(clock), .rst_n(rst_n), .motor_cmd(motor_cmd),
    .sample_stb(sample_stb), .motor_off(motor_off),
    .offset_level_setting(offset_level_setting),
    .sign_magnitude_select(sign_magnitude_select),
    .stepper_mode(stepper_mode), .pwm_enable(pwm_enable),
    .abort_n(abort_n), .off_on_error_setting(off_on_error_setting),
    .amp_on_cmd(amp_on_cmd), .step_cfg(step_cfg),
    .pos_err_mag(pos_err_mag), .error_limit_setting(error_limit_setting),
    .out_cmd(out_cmd), .motor_cmd_out(motor_cmd_out),
    .amp_enable(amp_enable), .pwm_step_out(pwm_step_out),
    .pwm_step_oe_n(pwm_step_oe_n), .sign_dir_out(sign_dir_out),
    .error_out_n(error_out_n), .gp_out(gp_out));
  mdo_amp_model amp (.clock(clock), .clr(clr), .pwm_step_out(pwm_step_out),
    .pwm_step_oe_n(pwm_step_oe_n), .pin(pin), .hi_cnt(hi_cnt),
    .edge_cnt(edge_cnt));

  always #50 clock = ~clock;

  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // window of n cycles on the pin, high cycles and rising edges expected
  task automatic meas(input int n, input int hi, input int ed);
    clr = 1;
    step(1);
    clr = 0;
    step(n);
    chk("high cycles", hi, hi_cnt);
    chk("rising edges", ed, edge_cnt);
  endtask

  task automatic do_reset(input logic sel);
    rst_n = 0;
    sign_magnitude_select = sel;
    step(4);
    rst_n = 1;
    step(1);
    chk("oe_n", {31'd0, ~sel}, {31'd0, pwm_step_oe_n});
    chk("pin", sel ? 32'd0 : {31'd0, 1'bz}, {31'd0, pin});
    step(3);
    chk("amp", 0, amp_enable);
  endtask

  task automatic load(input int c);
    motor_cmd = CMD_W'(c);
    sample_stb = 1;
    step(1);
    sample_stb = 0;
  endtask

  function automatic int inv_hi(input int c);
    int v;
    v = INV_MID + ((c * INV_SPAN) >>> SCALE_SH);
    return v < INV_MIN_HI ? INV_MIN_HI : (v > INV_MAX_HI ? INV_MAX_HI : v);
  endfunction

  initial begin
    do_reset(1'b1);
    do_reset(1'b0);
    load(16'h2345);
    chk("cmd out", 16'h2345, motor_cmd_out);
    motor_off = 1;
    step(2);
    chk("cmd out", 16'h1234, motor_cmd_out);
    load(16'h0042);
    chk("cmd out", 16'h1234, motor_cmd_out);
    motor_off = 0;
    amp_on_cmd = 1;
    step(1);
    amp_on_cmd = 0;
    chk("amp", 1, amp_enable);
    abort_n = 0;
    step(1);
    chk("amp", 0, amp_enable);
    abort_n = 1;
    amp_on_cmd = 1;
    step(1);
    amp_on_cmd = 0;
    pos_err_mag[5] = 16'h0100;
    off_on_error_setting = 1;
    step(2);
    chk("err", 1, error_out_n);
    chk("amp", 1, amp_enable);
    pos_err_mag[5] = 16'h0101;
    step(2);
    chk("err", 0, error_out_n);
    chk("amp", 0, amp_enable);
    pos_err_mag[5] = '0;
    out_cmd = '{0, 0, 1, 3'd0, 8'hA5};
    step(1);
    chk("gp", 8'hA5, gp_out);
    out_cmd = '{1, 0, 0, 3'd1, 8'h00};
    step(1);
    chk("gp", 8'hA7, gp_out);
    out_cmd = '{0, 1, 0, 3'd7, 8'h00};
    step(1);
    out_cmd = '0;
    chk("gp", 8'h27, gp_out);
    foreach (cmds[i]) begin
      load(cmds[i]);
      step(2 * INV_PERIOD + 4);
      meas(2 * INV_PERIOD, 2 * inv_hi(cmds[i]), 2);
    end
    sign_magnitude_select = 1;
    load(-16384);
    step(3 * SM_PERIOD);
    chk("sign", 1, sign_dir_out);
    meas(2 * SM_PERIOD, 2 * ((16384 * SM_MAX_HI) >> SCALE_SH), 2);
    load(-32768);
    step(3 * SM_PERIOD);
    meas(SM_PERIOD, SM_MAX_HI, 1);
    load(0);
    step(3 * SM_PERIOD);
    meas(SM_PERIOD, 0, 0);
    stepper_mode = 1;
    for (int p = 0; p < 2; p++) begin
      step_cfg = '{1'b1, p[0], p[0], 16'd5};
      step(20);
      chk("dir", p, sign_dir_out);
      meas(100, 50, 10);
      step_cfg.run = 0;
      step(4);
      chk("idle pin", {31'd0, ~p[0]}, {31'd0, pin});
    end
    print_verdict();
  end
endmodule
